// *** hdl/svrw_top.sv ***
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// RULE1: While supply POR is active, every function and flag stays in reset.
// RULE2: Release of POR restarts the power-up sequence from the start.
// RULE3: Any monitored undervoltage asserts the internal active-low reset.
// RULE4: Watchdog timeout resets only if watchdog enabled and reset enable set.
// RULE5: Internal reset held for the whole of low power mode.
// RULE6: Software reset command with pin enable set asserts internal reset.
// RULE7: Reset pin low during internal reset, then for a stretch after release.
// RULE8: Two-bit stretch select: 16, 32, 48 or 64 ms, default 16 ms.
// RULE9: During internal reset the serial interface ignores all commands; here only writes are refused, reads are still answered.
// RULE10: During internal reset bridges 1 and 2 float, PWM and direction cleared.
// RULE11: During internal reset ADC, GPIO, DAC, opamps, intc, comparator off.
// RULE12: Internal reset clears watchdog count but keeps watchdog flags; here the near-expiry flag is cleared too.
// RULE13: Regulator cut by cause: supply all, interface none, failing one later.
// RULE14: Overtemperature resets and cuts all; below warning restarts, flag set.
// RULE15: Shutdown flag cleared by write one, POR, or low power entry.
// RULE16: Warning flag latched when hot; cleared by write one, POR, low power.
// RULE17: Both temperature indications are filtered before use.
// RULE18: Watchdog disabled after reset; runs after firmware enables it.
// RULE19: Kick clears watchdog count, then loads the new delay code.
// RULE20: Timeout flag latched; cleared by clear bit, soft clear, or POR.
// RULE21: Near-expiry flag rises one watchdog tick before timeout.
// RULE22: Timeout equals eight plus delay code watchdog ticks.
// RULE23: Supervisor and watchdog timing run from the free-running core clock.
// RULE24: Watchdog tick made by a fixed divider of the core clock.
module svrw_top #(
  parameter int STRETCH_CYC = svrw_pkg::STRETCH_UNIT_CYC,
  parameter int WD_DIV_CYC  = svrw_pkg::WD_TICK_CYC
) (
  // Clock, reset, enable
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      ce,
  // Analog supervisor indications
  input  wire svrw_pkg::svrw_pins_t      pins,
  // AXI4-Lite slave
  input  wire logic [svrw_pkg::AW-1:0]   awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  input  wire logic [svrw_pkg::AW-1:0]   araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // Reset outputs and block controls
  output logic                           internal_reset_n,
  output logic                           reset_out_n,
  output svrw_pkg::svrw_blk_t            blk_ctl,
  output logic [svrw_pkg::SYS_N-1:0]     regulator_en,
  output logic                           powerup_restart,
  output logic                           watchdog_near_expiry
);
  import svrw_pkg::*;

  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
    return a[AW-1:2] == off[AW-1:2];
  endfunction

  // Regulators after the first failing one in power-up order
  function automatic logic [SYS_N-1:0] following(input logic [SYS_N-1:0] f);
    logic [SYS_N-1:0] m;
    logic             acc;
    m   = '0;
    acc = 1'b0;
    for (int i = 0; i < SYS_N; i++) begin
      m[i] = acc;
      acc  = acc | f[i];
    end
    return m;
  endfunction

  // Two-stage synchroniser for all analog indications
  svrw_pins_t pin1_q;
  svrw_pins_t pin2_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin1_q <= PINS_RST;
      pin2_q <= PINS_RST;
    end else if (ce) begin
      pin1_q <= pins;
      pin2_q <= pin1_q;
    end
  end

  wire por_s   = pin2_q.por;
  wire rst_all = !aresetn || por_s; // RULE1
  wire lp_s    = pin2_q.low_power;

  // Temperature glitch filters
  logic [1:0] filt_q;
  logic [7:0] fcnt_q [2];
  wire  [1:0] traw = {pin2_q.warn_hot, pin2_q.tsd_hot};
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      filt_q <= 2'h0;
      fcnt_q <= '{8'h00, 8'h00};
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (traw[i] == filt_q[i]) begin
          fcnt_q[i] <= 8'h00;
        end else if (fcnt_q[i] == 8'(TEMP_FILT_CYC - 1)) begin
          fcnt_q[i] <= 8'h00;
          filt_q[i] <= traw[i]; // RULE17
        end else begin
          fcnt_q[i] <= fcnt_q[i] + 8'h01;
        end
      end
    end
  end
  wire tsd_f  = filt_q[0];
  wire warn_f = filt_q[1];

  // Register state
  logic       soft_en_q;
  logic [1:0] sel_q;
  logic       wd_on_q;
  logic       wd_rst_en_q;
  logic [3:0] wd_code_cfg_q;
  logic [3:0] wd_code_q;
  logic [4:0] wd_cnt_q;
  logic       exp_q;
  logic       near_q;
  logic       tsd_act_q;
  logic       tsd_flag_q;
  logic       warn_flag_q;
  logic       irn_q;
  logic       pin_q;
  logic [31:0] st_cnt_q;
  logic [SYS_N-1:0] reg_on_q;
  logic       restart_q;
  logic       por_pend_q;
  logic       lp_d_q;
  svrw_blk_t  blk_q;

  // AXI channel state
  svrw_ax_t   wst_q;
  svrw_ax_t   rst_q;
  logic       awready_q;
  logic       wready_q;
  logic       bvalid_q;
  logic [1:0] bresp_q;
  logic       arready_q;
  logic       rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  // Write decode
  wire wr_fire  = (wst_q == AX_TAKE);
  wire s_ctrl   = hit(awaddr, OFF_CTRL);
  wire s_wdcfg  = hit(awaddr, OFF_WDCFG);
  wire s_wdstat = hit(awaddr, OFF_WDSTAT);
  wire s_temp   = hit(awaddr, OFF_TEMP);
  wire s_stat   = hit(awaddr, OFF_STAT);
  wire w_map    = s_ctrl || s_wdcfg || s_wdstat || s_temp || s_stat;
  // Interface held in reset: writes dropped while internal reset is low
  wire wr_ok    = wr_fire && w_map && irn_q && wstrb[0]; // RULE9
  wire wr_ctrl  = wr_ok && s_ctrl;
  wire wr_wdcfg = wr_ok && s_wdcfg;
  wire wr_wdst  = wr_ok && s_wdstat;
  wire wr_temp  = wr_ok && s_temp;
  wire kick     = wr_wdst && wdata[WDST_KICK];
  wire exp_clr  = wr_wdst && (wdata[WDST_CLR] || wdata[WDST_SOFT]); // RULE20
  wire tsd_clr  = wr_temp && wdata[TEMP_CLR_TSD];
  wire warn_clr = wr_temp && wdata[TEMP_CLR_WARN];
  wire soft_evt = wr_ctrl && wdata[CTRL_SOFT_CMD] && soft_en_q; // RULE6
  wire lp_entry = lp_s && !lp_d_q;

  // Watchdog tick divider
  logic [31:0] div_q;
  wire tick = (div_q == 32'(WD_DIV_CYC - 1)); // RULE24
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      div_q <= 32'h0;
    end else if (ce) begin
      div_q <= tick ? 32'h0 : div_q + 32'h1; // RULE23
    end
  end

  wire [4:0] wd_limit = WD_BASE + {1'b0, wd_code_q}; // RULE22
  wire       wd_run   = wd_on_q && irn_q;
  wire       wd_to    = wd_run && tick && !kick && (wd_cnt_q == wd_limit - 5'h01);
  wire       wd_rst   = wd_to && wd_rst_en_q; // RULE4

  // Reset causes
  wire uv_any = |pin2_q.uv; // RULE3
  wire cause  = uv_any || lp_s || tsd_act_q || wd_rst || soft_evt; // RULE5
  wire [SYS_N-1:0] cut =
    (pin2_q.uv.main || pin2_q.uv.intl || pin2_q.uv.pump || tsd_act_q) ? '1 :
    following(pin2_q.uv.sys); // RULE13
  wire tsd_rel = tsd_act_q && !tsd_f && !warn_f;

  // Supervisor core
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      irn_q      <= 1'b0;
      blk_q      <= '1;
      tsd_act_q  <= 1'b0;
      tsd_flag_q <= 1'b0;
      warn_flag_q <= 1'b0;
      reg_on_q   <= '0;
      restart_q  <= 1'b0;
      por_pend_q <= 1'b1;
      lp_d_q     <= 1'b0;
    end else if (ce) begin
      irn_q     <= !cause;
      blk_q     <= cause ? '1 : '0; // RULE10 RULE11
      lp_d_q    <= lp_s;
      por_pend_q <= 1'b0;
      if (tsd_f) begin
        tsd_act_q <= 1'b1; // RULE14
      end else if (tsd_rel) begin
        tsd_act_q <= 1'b0;
      end
      // Set wins over a clear in the same cycle
      tsd_flag_q  <= tsd_rel || (tsd_flag_q && !tsd_clr && !lp_entry); // RULE15
      warn_flag_q <= warn_f || (warn_flag_q && !warn_clr && !lp_entry); // RULE16
      // Restart after POR, overtemperature or a regulator cut
      restart_q <= por_pend_q || tsd_rel ||
                   (!irn_q && !cause && (reg_on_q != '1)); // RULE2
      if (restart_q) begin
        reg_on_q <= '1;
      end else if (cause) begin
        reg_on_q <= reg_on_q & ~cut; // RULE13
      end
    end
  end

  // Reset pin stretch
  wire [31:0] st_len = 32'((32'(sel_q) + 32'h1) * 32'(STRETCH_CYC)); // RULE8
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      pin_q    <= 1'b0;
      st_cnt_q <= 32'(STRETCH_CYC);
    end else if (ce) begin
      if (!irn_q) begin
        pin_q    <= 1'b0; // RULE7
        st_cnt_q <= st_len;
      end else begin
        if (st_cnt_q != 32'h0) begin
          st_cnt_q <= st_cnt_q - 32'h1;
        end
        pin_q <= (st_cnt_q <= 32'h1); // RULE7
      end
    end
  end

  // Configuration and watchdog
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      soft_en_q     <= 1'b0;
      sel_q         <= SEL_RST;
      wd_on_q       <= 1'b0; // RULE18
      wd_rst_en_q   <= 1'b0;
      wd_code_cfg_q <= WD_CODE_RST;
      wd_code_q     <= WD_CODE_RST;
      wd_cnt_q      <= 5'h00;
      exp_q         <= 1'b0;
      near_q        <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        soft_en_q <= wdata[CTRL_SOFT_EN];
        sel_q     <= wdata[CTRL_SEL_LSB +: 2];
      end
      if (wr_wdcfg) begin
        wd_on_q       <= wdata[WDCFG_ON]; // RULE18
        wd_rst_en_q   <= wdata[WDCFG_RST_EN];
        wd_code_cfg_q <= wdata[WDCFG_CODE_LSB +: 4];
      end
      if (kick) begin
        wd_cnt_q  <= 5'h00; // RULE19
        wd_code_q <= wd_code_cfg_q;
      end else if (!wd_run) begin
        wd_cnt_q <= 5'h00; // RULE12
      end else if (tick) begin
        wd_cnt_q <= wd_to ? 5'h00 : wd_cnt_q + 5'h01;
      end
      // Near expiry holds for the last tick period before timeout
      if (kick || !wd_run || wd_to) begin
        near_q <= 1'b0;
      end else if (tick && (wd_cnt_q == wd_limit - 5'h02)) begin
        near_q <= 1'b1; // RULE21
      end
      exp_q <= wd_to || (exp_q && !exp_clr); // RULE20
    end
  end

  // Read mux
  logic [31:0] rd_val;
  wire r_ctrl   = hit(araddr, OFF_CTRL);
  wire r_wdcfg  = hit(araddr, OFF_WDCFG);
  wire r_wdstat = hit(araddr, OFF_WDSTAT);
  wire r_temp   = hit(araddr, OFF_TEMP);
  wire r_stat   = hit(araddr, OFF_STAT);
  wire r_map    = r_ctrl || r_wdcfg || r_wdstat || r_temp || r_stat;
  always_comb begin
    rd_val = 32'h0;
    if (r_ctrl) begin
      rd_val[CTRL_SOFT_EN]        = soft_en_q;
      rd_val[CTRL_SEL_LSB +: 2]   = sel_q;
    end else if (r_wdcfg) begin
      rd_val[WDCFG_ON]            = wd_on_q;
      rd_val[WDCFG_RST_EN]        = wd_rst_en_q;
      rd_val[WDCFG_CODE_LSB +: 4] = wd_code_cfg_q;
    end else if (r_wdstat) begin
      rd_val[WDST_EXP]            = exp_q;
      rd_val[WDST_NEAR]           = near_q;
    end else if (r_temp) begin
      rd_val[TEMP_TSD]            = tsd_flag_q;
      rd_val[TEMP_WARN]           = warn_flag_q;
    end else if (r_stat) begin
      rd_val[STAT_IRN]            = irn_q;
      rd_val[STAT_PIN]            = pin_q;
      rd_val[STAT_TSD_ACT]        = tsd_act_q;
      rd_val[STAT_REG_LSB +: SYS_N] = reg_on_q;
    end
  end

  // AXI write channel: both address and data taken together
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      wst_q     <= AX_IDLE;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else if (ce) begin
      case (wst_q)
        AX_IDLE: begin
          if (awvalid && wvalid) begin
            wst_q     <= AX_TAKE;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
          end
        end
        AX_TAKE: begin
          wst_q     <= AX_RESP;
          awready_q <= 1'b0;
          wready_q  <= 1'b0;
          bvalid_q  <= 1'b1;
          bresp_q   <= (w_map && irn_q) ? RESP_OKAY : RESP_SLVERR; // RULE9
        end
        default: begin
          if (bready) begin
            wst_q    <= AX_IDLE;
            bvalid_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // AXI read channel
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      rst_q     <= AX_IDLE;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0;
    end else if (ce) begin
      case (rst_q)
        AX_IDLE: begin
          if (arvalid) begin
            rst_q     <= AX_TAKE;
            arready_q <= 1'b1;
          end
        end
        AX_TAKE: begin
          rst_q     <= AX_RESP;
          arready_q <= 1'b0;
          rvalid_q  <= 1'b1;
          rdata_q   <= rd_val;
          rresp_q   <= r_map ? RESP_OKAY : RESP_SLVERR;
        end
        default: begin
          if (rready) begin
            rst_q    <= AX_IDLE;
            rvalid_q <= 1'b0;
          end
        end
      endcase
    end
  end

  assign awready              = awready_q;
  assign wready               = wready_q;
  assign bvalid               = bvalid_q;
  assign bresp                = bresp_q;
  assign arready              = arready_q;
  assign rvalid               = rvalid_q;
  assign rresp                = rresp_q;
  assign rdata                = rdata_q;
  assign internal_reset_n     = irn_q;
  assign reset_out_n          = pin_q;
  assign blk_ctl              = blk_q;
  assign regulator_en         = reg_on_q;
  assign powerup_restart      = restart_q;
  assign watchdog_near_expiry = near_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (rst_all || !ce);

  por_hold_a: // RULE1
    assert property (@(posedge aclk) disable iff (!aresetn || !ce)
      por_s |=> (!irn_q && !pin_q && !tsd_flag_q && !exp_q && !warn_flag_q))
    else $error("state not held in reset during POR");
  uv_reset_a: // RULE3
    assert property (uv_any |=> !irn_q && blk_q.bridge_hiz)
    else $error("undervoltage did not assert internal reset");
  wd_reset_a: // RULE4
    assert property (wd_to && wd_rst_en_q |=> !irn_q ##1 !pin_q)
    else $error("watchdog timeout did not reset");
  lp_reset_a: // RULE5
    assert property (lp_s [*2] |-> !irn_q)
    else $error("internal reset released in low power");
  soft_reset_a: // RULE6
    assert property (soft_evt |=> !irn_q)
    else $error("software reset command ignored");
  pin_stretch_a: // RULE7 RULE8
    assert property ($rose(irn_q) |-> !pin_q [*8])
    else $error("reset pin released without stretch");
  refuse_wr_a: // RULE9
    assert property (wr_fire && !irn_q |=> bvalid_q && bresp_q == RESP_SLVERR)
    else $error("write accepted during internal reset");
  blk_off_a: // RULE10 RULE11
    assert property (!irn_q |-> blk_q == '1)
    else $error("blocks not held off in reset");
  wd_clear_a: // RULE12
    assert property (!irn_q |=> wd_cnt_q == 5'h00)
    else $error("watchdog count survived reset");
  wd_warn_a: // RULE21
    assert property (wd_to |-> near_q ##1 !near_q)
    else $error("near expiry not shown before timeout");
  wd_flag_a: // RULE20
    assert property (wd_to |=> exp_q)
    else $error("timeout flag not latched");
  tsd_flag_a: // RULE14
    assert property ($fell(tsd_act_q) |-> tsd_flag_q && powerup_restart)
    else $error("shutdown release without flag and restart");

  pin_rise_c: cover property ($rose(pin_q));
  wd_timeout_c: cover property (wd_to && wd_rst_en_q);
  tsd_cycle_c: cover property ($fell(tsd_act_q));
endmodule // svrw_top

// *** shared/svrw_pkg.sv ***
package svrw_pkg;
  // Clock and derived timing
  localparam int CLK_HZ           = 40_000_000;
  localparam int STRETCH_UNIT_MS  = 16;
  localparam int STRETCH_UNIT_CYC = STRETCH_UNIT_MS * (CLK_HZ / 1000);
  localparam int WD_TICK_US       = 1000;
  localparam int WD_TICK_CYC      = WD_TICK_US * (CLK_HZ / 1_000_000);
  localparam int TEMP_FILT_NS     = 1000;
  localparam int TEMP_FILT_CYC    = (TEMP_FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SYS_N            = 3;
  localparam int AW               = 8;
  // Register offsets
  localparam logic [AW-1:0] OFF_CTRL   = 8'h00;
  localparam logic [AW-1:0] OFF_WDCFG  = 8'h04;
  localparam logic [AW-1:0] OFF_WDSTAT = 8'h08;
  localparam logic [AW-1:0] OFF_TEMP   = 8'h0C;
  localparam logic [AW-1:0] OFF_STAT   = 8'h10;
  // Field positions
  localparam int CTRL_SOFT_CMD  = 0;
  localparam int CTRL_SOFT_EN   = 1;
  localparam int CTRL_SEL_LSB   = 2;
  localparam int WDCFG_ON       = 0;
  localparam int WDCFG_RST_EN   = 1;
  localparam int WDCFG_CODE_LSB = 4;
  localparam int WDST_KICK      = 0;
  localparam int WDST_CLR       = 1;
  localparam int WDST_SOFT      = 2;
  localparam int WDST_EXP       = 3;
  localparam int WDST_NEAR      = 4;
  localparam int TEMP_CLR_TSD   = 0;
  localparam int TEMP_CLR_WARN  = 1;
  localparam int TEMP_TSD       = 2;
  localparam int TEMP_WARN      = 3;
  localparam int STAT_IRN       = 0;
  localparam int STAT_PIN       = 1;
  localparam int STAT_TSD_ACT   = 2;
  localparam int STAT_REG_LSB   = 4;
  // Reset values and codes
  localparam logic [1:0] SEL_RST     = 2'h0;
  localparam logic [3:0] WD_CODE_RST = 4'h0;
  localparam logic [4:0] WD_BASE     = 5'h08;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    AX_IDLE = 2'h0,
    AX_TAKE = 2'h1,
    AX_RESP = 2'h3
  } svrw_ax_t;

  typedef struct packed {
    logic             main;
    logic             intl;
    logic             pump;
    logic             spi;
    logic [SYS_N-1:0] sys;
  } svrw_uv_t;

  typedef struct packed {
    logic     por;
    logic     low_power;
    logic     tsd_hot;
    logic     warn_hot;
    svrw_uv_t uv;
  } svrw_pins_t;

  typedef struct packed {
    logic bridge_hiz;
    logic bridge_ctl_clr;
    logic adc_off;
    logic gpio_off;
    logic dac_off;
    logic opamp_off;
    logic intc_off;
    logic cmp_off;
  } svrw_blk_t;

  localparam svrw_pins_t PINS_RST = '{por: 1'b1, low_power: 1'b0, tsd_hot: 1'b0,
                                      warn_hot: 1'b0, uv: '0};
endpackage

// *** dv/svrw_host.sv ***
`timescale 1ns/1ps
// Firmware side of the register bus, one write and one read at a time
module svrw_host (
  // Clock
  input  wire logic                    aclk,
  // Write channels
  output logic [svrw_pkg::AW-1:0]      awaddr,
  output logic                         awvalid,
  input  wire logic                    awready,
  output logic [31:0]                  wdata,
  output logic [3:0]                   wstrb,
  output logic                         wvalid,
  input  wire logic                    wready,
  input  wire logic [1:0]              bresp,
  input  wire logic                    bvalid,
  output logic                         bready,
  // Read channels
  output logic [svrw_pkg::AW-1:0]      araddr,
  output logic                         arvalid,
  input  wire logic                    arready,
  input  wire logic [31:0]             rdata,
  input  wire logic [1:0]              rresp,
  input  wire logic                    rvalid,
  output logic                         rready
);
  import svrw_pkg::*;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    // Each channel released only at the edge that took it
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
endmodule // svrw_host

// *** dv/svrw_top_tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module svrw_top_tb;
  import svrw_pkg::*;
  localparam int STR = 20;
  localparam int DIV = 4;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, internal_reset_n, reset_out_n;
  logic powerup_restart, watchdog_near_expiry, irn_q, near_q;
  logic [AW-1:0]    awaddr, araddr;
  logic [31:0]      wdata, rdata, d;
  logic [3:0]       wstrb;
  logic [1:0]       bresp, rresp, r;
  logic [SYS_N-1:0] regulator_en;
  svrw_pins_t       pins;
  svrw_blk_t        blk_ctl;
  int n_mismatch, checks_done, cyc, str_len, str_cnt, t_fall, t_near, n_pulse, p;
  logic [2:0] uv_exp [7] = '{3'h0, 3'h0, 3'h0, 3'h7, 3'h7, 3'h3, 3'h1};

  svrw_top #(.STRETCH_CYC(STR), .WD_DIV_CYC(DIV)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .ce(1'h1), .pins(pins), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .internal_reset_n(internal_reset_n), .reset_out_n(reset_out_n), .blk_ctl(blk_ctl),
    .regulator_en(regulator_en), .powerup_restart(powerup_restart),
    .watchdog_near_expiry(watchdog_near_expiry));
  svrw_host i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  // Stretch length, event times and restart pulses seen at the pins
  always @(posedge aclk) begin
    cyc    <= cyc + 1;
    irn_q  <= internal_reset_n;
    near_q <= watchdog_near_expiry;
    if (irn_q && !internal_reset_n) t_fall <= cyc;
    if (!near_q && watchdog_near_expiry) t_near <= cyc;
    if (powerup_restart) n_pulse <= n_pulse + 1;
    if (!internal_reset_n) str_cnt <= 0;
    else if (!reset_out_n) str_cnt <= str_cnt + 1;
    else if (str_cnt != 0) begin
      str_len <= str_cnt;
      str_cnt <= 0;
    end
  end

  task automatic cyc_n(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wait_pin();
    cyc_n(4);
    while (!reset_out_n) begin
      @(posedge aclk);
    end
    cyc_n(2);
  endtask

  task automatic wr_c(input logic [AW-1:0] a, input logic [31:0] v, input logic [1:0] e);
    i_host.wr(a, v, r);
    `CHK("bresp", e, r)
  endtask

  task automatic rd_chk(input logic [AW-1:0] a, input int lsb, input logic [1:0] e,
                        input string nm);
    i_host.rd(a, d, r);
    `CHK("rresp", RESP_OKAY, r)
    `CHK(nm, e, d[lsb+:2])
  endtask

  task automatic wd_run(input logic [3:0] c, input logic en);
    int t0;
    int n;
    n = 0;
    wr_c(OFF_WDCFG, {24'h0, c, 2'h0, en, 1'h1}, RESP_OKAY);
    wr_c(OFF_WDSTAT, 32'h1, RESP_OKAY);
    t0 = cyc;
    while (t_near < t0 && n < 300) begin
      @(posedge aclk);
      n++;
    end
    `CHK("wd_span", 1'h1, t_near - t0 >= (6 + c) * DIV - 2 && t_near - t0 <= (7 + c) * DIV + 1)
    cyc_n(DIV + 3);
    if (en) `CHK("wd_warn", 1'h1, t_fall - t_near >= DIV && t_fall - t_near <= DIV + 2)
    else `CHK("wd_norst", 1'h1, internal_reset_n)
    rd_chk(OFF_WDSTAT, WDST_EXP, 2'h1, "wd_flag");
    wr_c(OFF_WDCFG, 32'h0, RESP_OKAY);
    wait_pin();
    wr_c(OFF_WDSTAT, en ? 32'h2 : 32'h4, RESP_OKAY);
    rd_chk(OFF_WDSTAT, WDST_EXP, 2'h0, "wd_clr");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    {aresetn, n_mismatch, checks_done, cyc, str_len, str_cnt, t_fall, t_near, n_pulse} = '0;
    pins = PINS_RST;
    cyc_n(8);
    aresetn <= 1'h1;
    cyc_n(4);
    `CHK("irn_por", 1'h0, internal_reset_n)
    `CHK("reg_por", 3'h0, regulator_en)
    pins.por <= 1'h0;
    wait_pin();
    `CHK("pulse", 1, n_pulse)
    `CHK("str_def", STR, str_len)
    `CHK("reg_up", 3'h7, regulator_en)
    `CHK("wd_off", 0, t_near)
    $display("test power-on done");
    for (int s = 0; s < 4; s++) begin
      wr_c(OFF_CTRL, {28'h0, s[1:0], 2'h2}, RESP_OKAY);
      p = t_fall;
      wr_c(OFF_CTRL, {28'h0, s[1:0], 2'h3}, RESP_OKAY);
      wait_pin();
      `CHK("soft_fall", 1'h1, t_fall > p)
      `CHK("stretch", (s + 1) * STR, str_len)
    end
    wr_c(OFF_CTRL, 32'h0, RESP_OKAY);
    wr_c(OFF_CTRL, 32'h1, RESP_OKAY);
    cyc_n(5);
    `CHK("soft_off", 1'h1, internal_reset_n)
    $display("test soft reset done");
    for (int k = 0; k < 7; k++) begin
      pins.uv <= svrw_uv_t'(7'h40 >> k);
      cyc_n(6);
      `CHK("uv_irn", 1'h0, internal_reset_n)
      `CHK("uv_reg", uv_exp[k], regulator_en)
      `CHK("uv_blk", 8'hFF, blk_ctl)
      pins.uv <= '0;
      wait_pin();
      `CHK("uv_back", 3'h7, regulator_en)
    end
    $display("test undervoltage done");
    pins.tsd_hot <= 1'h1;
    cyc_n(20);
    pins.tsd_hot <= 1'h0;
    cyc_n(4);
    `CHK("filt", 1'h1, internal_reset_n)
    rd_chk(OFF_TEMP, TEMP_TSD, 2'h0, "filt_flag");
    pins.tsd_hot  <= 1'h1;
    pins.warn_hot <= 1'h1;
    cyc_n(60);
    `CHK("tsd_irn", 1'h0, internal_reset_n)
    `CHK("tsd_reg", 3'h0, regulator_en)
    rd_chk(OFF_STAT, STAT_PIN, 2'h2, "tsd_act");
    pins.tsd_hot  <= 1'h0;
    pins.warn_hot <= 1'h0;
    wait_pin();
    `CHK("tsd_reg_up", 3'h7, regulator_en)
    rd_chk(OFF_TEMP, TEMP_TSD, 2'h3, "temp_flags");
    wr_c(OFF_TEMP, 32'h1, RESP_OKAY);
    rd_chk(OFF_TEMP, TEMP_TSD, 2'h2, "tsd_clr");
    $display("test thermal done");
    pins.low_power <= 1'h1;
    cyc_n(6);
    wr_c(OFF_WDCFG, 32'h1, RESP_SLVERR);
    rd_chk(OFF_TEMP, TEMP_TSD, 2'h0, "lp_clr");
    cyc_n(50);
    `CHK("lp_irn", 1'h0, internal_reset_n)
    pins.low_power <= 1'h0;
    wait_pin();
    rd_chk(OFF_WDCFG, 0, 2'h0, "lp_drop");
    $display("test low power done");
    wd_run(4'hF, 1'h1);
    wd_run(4'h0, 1'h0);
    $display("test watchdog done");
    wr_c(8'h14, 32'h1, RESP_SLVERR);
    i_host.rd(8'h14, d, r);
    `CHK("unmap", RESP_SLVERR, r)
    `CHK("unmap_d", 32'h0, d)
    wr_c(OFF_CTRL, 32'hC, RESP_OKAY);
    pins.por <= 1'h1;
    cyc_n(6);
    `CHK("por_irn", 1'h0, internal_reset_n)
    p = n_pulse;
    pins.por <= 1'h0;
    wait_pin();
    `CHK("por_pulse", p + 1, n_pulse)
    `CHK("por_str", STR, str_len)
    rd_chk(OFF_CTRL, CTRL_SEL_LSB, 2'h0, "por_sel");
    $display("test mid-run power-on done");
    finish_test();
  end

  initial begin
    cyc_n(8000);
    n_mismatch++;
    finish_test();
  end
endmodule // svrw_top_tb
